/* File: include/sta_defs.vh */
// constants for the serial adapter: offsets, fields, reset values, timing
`ifndef STA_DEFS_VH
`define STA_DEFS_VH
// register word offsets
`define STA_OFF_DATA 4'h0
`define STA_OFF_CMD 4'h1
`define STA_OFF_STAT 4'h2
`define STA_OFF_IRQ_STAT 4'h3
`define STA_OFF_IRQ_EN 4'h4
`define STA_OFF_IRQ_CLR 4'h5
`define STA_OFF_LOAD_ADDR 4'h6
// command codes written to the command register
`define STA_CMD_WRAP_ON 8'h01
`define STA_CMD_WRAP_OFF 8'h02
`define STA_CMD_RESET 8'h03
// status bit positions
`define STA_ST_TX_BUSY 0
`define STA_ST_RX_FULL 1
`define STA_ST_WRAP 2
`define STA_ST_OVERRUN 3
`define STA_ST_LOAD 4
// interrupt bit positions
`define STA_IRQ_TX_DONE 0
`define STA_IRQ_RX_DONE 1
`define STA_IRQ_WRAP 2
`define STA_IRQ_OVERRUN 3
// reset values
`define STA_IRQ_EN_RST 4'h0
`define STA_LOAD_ADDR_RST 16'h0000
// frame layout: start, eight data, two stop
`define STA_FRAME_BITS 11
`define STA_DATA_BITS 8
// bit rate table: jumper code selects bits per second
`define STA_CLK_HZ 200000000
`define STA_BAUD0 110
`define STA_BAUD1 300
`define STA_BAUD2 1200
`define STA_BAUD3 9600
`endif

/* File: tb/sta_adapter_props.sv */
// port checker for the serial adapter, bound to its top module
`timescale 1ns/100ps
`include "sta_defs.vh"
module sta_adapter_props
(
    input wire CLK,
    input wire RST,
    input wire [1:0] RATE_SEL,
    input wire MARK_HIGH,
    input wire LOAD_MODE,
    input wire [3:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [15:0] RDATA,
    input wire IRQ,
    input wire CS_REQ,
    input wire [15:0] CS_ADDR,
    input wire [7:0] CS_DATA,
    input wire CS_ACK,
    input wire TXD,
    input wire RXD
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------
    // steal handshake steps
    // ------------------------------------------------
    // a soft reset command may legally cancel a pending request
    sequence cs_wait;
        CS_REQ && !CS_ACK && !(WR && ADDR == `STA_OFF_CMD);
    endsequence
    sequence cs_grant;
        CS_REQ && CS_ACK;
    endsequence
    // read data stand only in the cycle after the strobe
    chk_rdata_quiet: assert property (
        !$past(RD) |-> RDATA == 16'h0000)
        else $error("read data seen without a read");
    chk_rdata_unmapped: assert property (
        RD && ADDR > 4'h6 |=> RDATA == 16'h0000)
        else $error("unmapped read returned data");
    // memory may stall; the byte must not slip meanwhile
    chk_cs_hold: assert property (
        cs_wait |=> CS_REQ && $stable(CS_ADDR) && $stable(CS_DATA))
        else $error("steal request changed while waiting");
    chk_cs_drop: assert property (
        cs_grant |=> !CS_REQ)
        else $error("steal request held after grant");
    chk_cs_load_only: assert property (
        !LOAD_MODE |-> !CS_REQ)
        else $error("cycle steal outside load mode");
    // line rests at the strapped mark level for two cycles out of reset
    chk_tx_mark_rest: assert property (
        $past(RST, 2) |-> TXD == MARK_HIGH)
        else $error("line not at mark after reset");
    chk_tx_start_len: assert property (
        $fell(TXD == MARK_HIGH) |-> (TXD != MARK_HIGH)[*8])
        else $error("start bit too short");
    // data bits may turn mark to space, so watch only before a first send
    logic sent_any;
    always @(posedge CLK)
    begin
        if (RST)
            sent_any <= 1'b0;
        else if (WR && ADDR == `STA_OFF_DATA)
            sent_any <= 1'b1;
    end
    // a frame starts within two cycles of a write or not at all
    chk_tx_quiet: assert property (
        (!sent_any && TXD == MARK_HIGH && !(WR && ADDR == `STA_OFF_DATA))[*3]
        |=> TXD == MARK_HIGH)
        else $error("line left mark without a write");
    chk_irq_mask: assert property (
        WR && ADDR == `STA_OFF_IRQ_EN && WDATA[3:0] == 4'h0 |=> !IRQ)
        else $error("interrupt raised while all masked");
endmodule // sta_adapter_props

bind sta_adapter sta_adapter_props sta_adapter_props_i (.CLK(CLK),
    .RST(RST), .RATE_SEL(RATE_SEL), .MARK_HIGH(MARK_HIGH),
    .LOAD_MODE(LOAD_MODE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .CS_REQ(CS_REQ), .CS_ADDR(CS_ADDR),
    .CS_DATA(CS_DATA), .CS_ACK(CS_ACK), .TXD(TXD), .RXD(RXD));

/* File: tb/sta_adapter_tb.sv */
// testbench for the serial adapter: registers, wrap, steal, line frame
`timescale 1ns/100ps
`include "sta_defs.vh"
module sta_adapter_tb;
    localparam int PER = `STA_CLK_HZ / `STA_BAUD3;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] rate_sel = 2'h3;
    logic mark_high = 1'b1;
    logic load_mode = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cs_ack = 1'b0;
    logic [15:0] rdata;
    logic irq;
    logic cs_req;
    logic [15:0] cs_addr;
    logic [7:0] cs_data;
    logic txd;
    logic rxd;
    logic [15:0] v;
    int mismatches = 0;
    int check_count = 0;
    always #2.5 clk = ~clk;
    sta_adapter sta_adapter_i (.CLK(clk), .RST(rst), .RATE_SEL(rate_sel),
        .MARK_HIGH(mark_high), .LOAD_MODE(load_mode), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
        .CS_REQ(cs_req), .CS_ADDR(cs_addr), .CS_DATA(cs_data),
        .CS_ACK(cs_ack), .TXD(txd), .RXD(rxd));
    sta_line_dev sta_line_dev_i (.clk(clk), .mark_high(mark_high),
        .line(rxd));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic chk(input string what, input [15:0] e, input [15:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic hang(input string what);
        mismatches++;
        $display("unexpected %s: expected 1 seen 0", what);
        test_done();
    endtask
    // straps change only while reset is held
    task automatic do_reset(input logic mh, input logic lm);
        @(posedge clk);
        rst <= 1'b1;
        mark_high <= mh;
        load_mode <= lm;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input [3:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input [3:0] a, output [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_regs;
        do_reset(1'b1, 1'b0);
        rd_reg(`STA_OFF_IRQ_EN, v);
        chk("irq enable reset", 16'h0000, v);
        rd_reg(`STA_OFF_LOAD_ADDR, v);
        chk("load address reset", 16'h0000, v);
        rd_reg(`STA_OFF_STAT, v);
        chk("status reset", 16'h0000, v);
        rd_reg(4'hF, v);
        chk("unmapped read", 16'h0000, v);
        chk("line idle", 16'h0001, {15'h0000, txd});
        $display("test registers done");
    endtask
    // control codes and extremes must loop back untouched
    task automatic t_wrap;
        logic [7:0] b [4] = '{8'h00, 8'hFF, 8'h13, 8'h80};
        for (int i = 0; i < 4; i++)
        begin
            do_reset(1'b0, 1'b0);
            wr_reg(`STA_OFF_CMD, {8'h00, `STA_CMD_WRAP_ON});
            wr_reg(`STA_OFF_DATA, {8'h00, b[i]});
            chk("masked irq", 16'h0000, {15'h0000, irq});
            rd_reg(`STA_OFF_IRQ_STAT, v);
            chk("wrap flag", 16'h0004, v & 16'h0004);
            rd_reg(`STA_OFF_STAT, v);
            chk("wrap state", 16'h0004, v & 16'h0004);
            wr_reg(`STA_OFF_IRQ_EN, 16'h0004);
            chk("irq raised", 16'h0001, {15'h0000, irq});
            wr_reg(`STA_OFF_IRQ_EN, 16'h0000);
            chk("irq masked again", 16'h0000, {15'h0000, irq});
            wr_reg(`STA_OFF_IRQ_EN, 16'h0004);
            rd_reg(`STA_OFF_DATA, v);
            chk("looped byte", {8'h00, b[i]}, v);
            wr_reg(`STA_OFF_IRQ_CLR, 16'h0004);
            chk("irq cleared", 16'h0000, {15'h0000, irq});
        end
        $display("test wrap done");
    endtask
    // memory stalls the grant for a few cycles
    task automatic t_steal;
        int n;
        do_reset(1'b1, 1'b1);
        wr_reg(`STA_OFF_LOAD_ADDR, 16'h0120);
        wr_reg(`STA_OFF_CMD, {8'h00, `STA_CMD_WRAP_ON});
        wr_reg(`STA_OFF_DATA, 16'h00C3);
        for (n = 0; n < 20 && cs_req !== 1'b1; n++)
            @(negedge clk);
        if (n == 20)
            hang("steal request");
        chk("steal data", 16'h00C3, {8'h00, cs_data});
        chk("steal address", 16'h0120, cs_addr);
        repeat (4) @(negedge clk);
        chk("request held", 16'h0001, {15'h0000, cs_req});
        @(posedge clk);
        cs_ack <= 1'b1;
        @(posedge clk);
        cs_ack <= 1'b0;
        #1;
        chk("request dropped", 16'h0000, {15'h0000, cs_req});
        rd_reg(`STA_OFF_LOAD_ADDR, v);
        chk("next load address", 16'h0121, v);
        wr_reg(`STA_OFF_CMD, {8'h00, `STA_CMD_WRAP_OFF});
        rd_reg(`STA_OFF_STAT, v);
        chk("wrap off", 16'h0000, v & 16'h0004);
        wr_reg(`STA_OFF_CMD, {8'h00, `STA_CMD_RESET});
        rd_reg(`STA_OFF_LOAD_ADDR, v);
        chk("soft reset address", 16'h0000, v);
        $display("test steal done");
    endtask
    // inverted polarity; receive runs while transmitting
    task automatic t_frame;
        int n;
        logic [7:0] b;
        b = 8'h5A;
        do_reset(1'b0, 1'b0);
        fork
            sta_line_dev_i.send(8'h96, PER);
        join_none
        wr_reg(`STA_OFF_DATA, {8'h00, b});
        for (n = 0; n < 3 && txd === mark_high; n++)
            @(negedge clk);
        if (n == 3)
            hang("start bit");
        repeat (PER / 2) @(negedge clk);
        chk("start mid", 16'h0001, {15'h0000, txd});
        for (int i = 0; i < 3; i++)
        begin
            repeat (PER) @(negedge clk);
            chk("data bit", {15'h0000, ~b[i]}, {15'h0000, txd});
        end
        $display("test frame done");
    endtask
    initial
    begin
        t_regs();
        t_wrap();
        t_steal();
        t_frame();
        test_done();
    end
endmodule // sta_adapter_tb

/* File: tb/sta_line_dev.sv */
// line-side model of a serial character device sending frames
`timescale 1ns/100ps
module sta_line_dev
(
    input wire clk,
    input wire mark_high,
    output logic line
);
    logic space_bit = 1'b0;
    // space is the inverse of the strapped mark level
    assign line = space_bit ? ~mark_high : mark_high;
    // start at space, low bit first, two stops back at mark
    task send(input logic [7:0] b, input int per);
        logic [10:0] sp;
        sp = {2'b00, ~b, 1'b1};
        for (int i = 0; i < 11; i++)
        begin
            space_bit <= sp[i];
            repeat (per) @(posedge clk);
        end
    endtask
endmodule // sta_line_dev

/* File: verilog/sta_adapter.v */
// serial character adapter: registers, transmitter, receiver, load mode
`timescale 1ns/100ps
`include "sta_defs.vh"
//
// Function
// [RULE1] transmit and receive run on separate lines and separate engines
// [RULE2] data bits go least significant first
// [RULE3] each byte rides in its own eleven-bit frame, framed separately
// [RULE4] frame is start at space, eight data, two stops at mark
// [RULE5] bit rate comes from a static jumper input only
// [RULE6] static input picks which level is mark on both lines
// [RULE7] every eight-bit value passes unchanged
// [RULE8] no parity and no control-character detection
// [RULE9] one byte per program command in normal operation
// [RULE10] in load mode received bytes go to memory by cycle steal
// [RULE11] diagnostic command enters wrap state, held for later commands
// [RULE12] wrapped write sends byte and loads it into receive register
// [RULE13] wrapped write raises an interrupt for read-back compare
module sta_adapter
(
    CLK,
    RST,
    RATE_SEL,
    MARK_HIGH,
    LOAD_MODE,
    ADDR,
    WDATA,
    WR,
    RD,
    RDATA,
    IRQ,
    CS_REQ,
    CS_ADDR,
    CS_DATA,
    CS_ACK,
    TXD,
    RXD
);
    input wire CLK;
    input wire RST;
    input wire [1:0] RATE_SEL;
    input wire MARK_HIGH;
    input wire LOAD_MODE;
    input wire [3:0] ADDR;
    input wire [15:0] WDATA;
    input wire WR;
    input wire RD;
    output reg [15:0] RDATA;
    output wire IRQ;
    output reg CS_REQ;
    output reg [15:0] CS_ADDR;
    output reg [7:0] CS_DATA;
    input wire CS_ACK;
    output reg TXD;
    input wire RXD;

    // --------------------------------------------------------------
    // states and local decode
    // --------------------------------------------------------------
    localparam TX_IDLE = 1'b0;
    localparam TX_SEND = 1'b1;
    localparam RX_IDLE = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA = 2'h2;
    localparam RX_STOP = 2'h3;

    // map a line level to logical mark (1) or space (0)
    function line_to_mark;
        input lvl;
        input mark_hi;
        begin
            line_to_mark = mark_hi ? lvl : !lvl;
        end
    endfunction

    wire wr_data = WR && ADDR == `STA_OFF_DATA;
    wire wr_cmd = WR && ADDR == `STA_OFF_CMD;
    wire rd_data = RD && ADDR == `STA_OFF_DATA;
    wire soft_rst = wr_cmd && WDATA[7:0] == `STA_CMD_RESET;

    reg wrap_reg;
    reg [1:0] rate_reg;
    reg mark_reg;
    reg load_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_en_reg;
    reg [15:0] load_addr_reg;

    // --------------------------------------------------------------
    // static straps, caught after reset
    // --------------------------------------------------------------
    // sampled every cycle out of reset so software never alters rate or polarity
    always @(posedge CLK)
    begin
        if (RST)
        begin
            rate_reg <= 2'h0;
            mark_reg <= MARK_HIGH;
            load_reg <= 1'b0;
        end
        else
        begin
            rate_reg <= RATE_SEL; // RULE5
            mark_reg <= MARK_HIGH; // RULE6
            load_reg <= LOAD_MODE;
        end
    end

    // --------------------------------------------------------------
    // transmitter
    // --------------------------------------------------------------
    reg tx_state_reg;
    reg [10:0] tx_shift_reg;
    reg [3:0] tx_cnt_reg;
    wire tx_tick;
    wire tx_start = wr_data && tx_state_reg == TX_IDLE;
    reg tx_done;

    sta_bit_timer u_tx_timer
    (
        .CLK(CLK),
        .RST(RST),
        .restart(tx_start),
        .rate_sel(rate_reg),
        .half_tick(),
        .tick(tx_tick)
    );

    // own engine and timer so receive runs concurrently
    always @(posedge CLK)
    begin
        tx_done <= 1'b0;
        if (RST || soft_rst)
        begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= {11{1'b1}};
            tx_cnt_reg <= 4'h0;
            TXD <= MARK_HIGH ? 1'b1 : 1'b0;
        end
        else
        begin
            case (tx_state_reg)
                TX_IDLE:
                begin
                    TXD <= mark_reg ? 1'b1 : 1'b0; // RULE4
                    if (tx_start)
                    begin
                        // stops, data unaltered, start; lsb nearest out
                        tx_shift_reg <= {2'b11, WDATA[7:0], 1'b0}; // RULE7
                        tx_cnt_reg <= 4'h0;
                        tx_state_reg <= TX_SEND; // RULE9
                    end
                end
                TX_SEND:
                begin
                    TXD <= mark_reg ? tx_shift_reg[0] : !tx_shift_reg[0];
                    if (tx_tick)
                    begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]}; // RULE2
                        tx_cnt_reg <= tx_cnt_reg + 1'b1;
                        if (tx_cnt_reg == `STA_FRAME_BITS - 1) // RULE3
                        begin
                            tx_state_reg <= TX_IDLE;
                            tx_done <= 1'b1;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // receiver
    // --------------------------------------------------------------
    reg [1:0] rx_state_reg;
    reg [7:0] rx_shift_reg;
    reg [3:0] rx_cnt_reg;
    reg [7:0] rx_data_reg;
    reg rx_full_reg;
    reg overrun_reg;
    reg rx_done;
    reg rx_over;
    wire rx_mark = line_to_mark(RXD, mark_reg); // RULE6
    wire rx_half;
    wire rx_edge = rx_state_reg == RX_IDLE && !rx_mark;
    // wrapped write loads the receive register too
    wire wrap_load = wr_data && wrap_reg && tx_start; // RULE12
    // memory takes the held byte in the cycle it grants
    wire cs_take = CS_REQ && CS_ACK;

    sta_bit_timer u_rx_timer // RULE1
    (
        .CLK(CLK),
        .RST(RST),
        .restart(rx_edge),
        .rate_sel(rate_reg),
        .half_tick(rx_half),
        .tick()
    );

    // sample mid-bit: half period after start edge, then whole periods
    always @(posedge CLK)
    begin
        rx_done <= 1'b0;
        if (RST || soft_rst)
        begin
            rx_state_reg <= RX_IDLE;
            rx_shift_reg <= 8'h00;
            rx_cnt_reg <= 4'h0;
        end
        else
        begin
            case (rx_state_reg)
                RX_IDLE:
                    if (rx_edge)
                        rx_state_reg <= RX_START; // RULE3
                RX_START:
                    if (rx_half)
                        rx_state_reg <= rx_mark ? RX_IDLE : RX_DATA;
                RX_DATA:
                    if (rx_half)
                    begin
                        rx_shift_reg <= {rx_mark, rx_shift_reg[7:1]}; // RULE2
                        rx_cnt_reg <= rx_cnt_reg + 1'b1;
                        if (rx_cnt_reg == `STA_DATA_BITS - 1)
                        begin
                            rx_cnt_reg <= 4'h0;
                            rx_state_reg <= RX_STOP;
                        end
                    end
                RX_STOP:
                    // first stop timed to mid-bit but its level not checked; second stop is idle line time
                    if (rx_half)
                    begin
                        rx_state_reg <= RX_IDLE;
                        rx_done <= 1'b1; // RULE8
                    end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // receive data register; a new byte before read sets overrun
    always @(posedge CLK)
    begin
        rx_over <= 1'b0;
        if (RST || soft_rst)
        begin
            rx_data_reg <= 8'h00;
            rx_full_reg <= 1'b0;
        end
        else if (rx_done || wrap_load)
        begin
            rx_data_reg <= wrap_load ? WDATA[7:0] : rx_shift_reg; // RULE12
            rx_full_reg <= 1'b1;
            rx_over <= rx_full_reg && !rd_data && !cs_take;
        end
        else if (rd_data || cs_take)
            rx_full_reg <= 1'b0; // RULE9
    end

    // --------------------------------------------------------------
    // cycle-steal delivery during program load
    // --------------------------------------------------------------
    always @(posedge CLK)
    begin
        if (RST || soft_rst)
        begin
            CS_REQ <= 1'b0;
            CS_ADDR <= `STA_LOAD_ADDR_RST;
            CS_DATA <= 8'h00;
        end
        else if (cs_take)
        begin
            CS_REQ <= 1'b0;
            CS_ADDR <= CS_ADDR + 16'h0001;
        end
        else if (load_reg && rx_full_reg && !CS_REQ && !rx_done)
        begin
            CS_REQ <= 1'b1; // RULE10
            CS_DATA <= rx_data_reg;
            CS_ADDR <= load_addr_reg;
        end
    end

    // --------------------------------------------------------------
    // command, wrap state and load address
    // --------------------------------------------------------------
    // wrap persists until turned off or reset
    always @(posedge CLK)
    begin
        if (RST || soft_rst)
        begin
            wrap_reg <= 1'b0;
            load_addr_reg <= `STA_LOAD_ADDR_RST;
        end
        else
        begin
            if (wr_cmd && WDATA[7:0] == `STA_CMD_WRAP_ON)
                wrap_reg <= 1'b1; // RULE11
            else if (wr_cmd && WDATA[7:0] == `STA_CMD_WRAP_OFF)
                wrap_reg <= 1'b0;
            if (WR && ADDR == `STA_OFF_LOAD_ADDR)
                load_addr_reg <= WDATA;
            else if (cs_take)
                load_addr_reg <= load_addr_reg + 16'h0001;
        end
    end

    // --------------------------------------------------------------
    // interrupts: sticky status, set wins over clear
    // --------------------------------------------------------------
    wire [3:0] irq_set = {rx_over, wrap_load, rx_done, tx_done};
    wire [3:0] irq_clr = (WR && ADDR == `STA_OFF_IRQ_CLR) ? WDATA[3:0] : 4'h0;
    always @(posedge CLK)
    begin
        if (RST || soft_rst)
        begin
            irq_stat_reg <= 4'h0;
            irq_en_reg <= `STA_IRQ_EN_RST;
        end
        else
        begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set; // RULE13
            if (WR && ADDR == `STA_OFF_IRQ_EN)
                irq_en_reg <= WDATA[3:0];
        end
    end
    assign IRQ = |(irq_stat_reg & irq_en_reg);

    always @(posedge CLK)
    begin
        if (RST)
            overrun_reg <= 1'b0;
        else if (rx_over)
            overrun_reg <= 1'b1;
        else if (rd_data || soft_rst)
            overrun_reg <= 1'b0;
    end

    // --------------------------------------------------------------
    // read port: data one cycle after strobe
    // --------------------------------------------------------------
    always @(posedge CLK)
    begin
        if (RST)
            RDATA <= 16'h0000;
        else if (RD)
        begin
            case (ADDR)
                `STA_OFF_DATA: RDATA <= {8'h00, rx_data_reg}; // RULE7
                `STA_OFF_STAT: RDATA <= {11'h000, load_reg, overrun_reg,
                    wrap_reg, rx_full_reg, tx_state_reg};
                `STA_OFF_IRQ_STAT: RDATA <= {12'h000, irq_stat_reg};
                `STA_OFF_IRQ_EN: RDATA <= {12'h000, irq_en_reg};
                `STA_OFF_LOAD_ADDR: RDATA <= load_addr_reg;
                default: RDATA <= 16'h0000;
            endcase
        end
        else
            RDATA <= 16'h0000;
    end
endmodule // sta_adapter

/* File: verilog/sta_bit_timer.v */
// bit timer: divides CLK to a one-cycle tick at the jumpered bit rate
`timescale 1ns/100ps
`include "sta_defs.vh"
module sta_bit_timer
#(
    parameter CW = 21,
    parameter DIV0 = `STA_CLK_HZ / `STA_BAUD0,
    parameter DIV1 = `STA_CLK_HZ / `STA_BAUD1,
    parameter DIV2 = `STA_CLK_HZ / `STA_BAUD2,
    parameter DIV3 = `STA_CLK_HZ / `STA_BAUD3
)
(
    input wire CLK,
    input wire RST,
    input wire restart,
    input wire [1:0] rate_sel,
    output reg half_tick,
    output reg tick
);
    reg [CW-1:0] cnt_reg;
    reg [CW-1:0] cnt_next;
    reg [CW-1:0] period;

    // period lookup from the static jumper code
    always @*
    begin
        case (rate_sel)
            2'h0: period = DIV0[CW-1:0];
            2'h1: period = DIV1[CW-1:0];
            2'h2: period = DIV2[CW-1:0];
            default: period = DIV3[CW-1:0];
        endcase
    end

    // restart lets the receiver align to a start edge
    always @*
    begin
        if (restart || cnt_reg >= period - 1'b1)
            cnt_next = {CW{1'b0}};
        else
            cnt_next = cnt_reg + 1'b1;
    end

    always @(posedge CLK)
    begin
        if (RST)
        begin
            cnt_reg <= {CW{1'b0}};
            tick <= 1'b0;
            half_tick <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            tick <= !restart && (cnt_reg == period - 1'b1);
            half_tick <= !restart && (cnt_reg == {1'b0, period[CW-1:1]});
        end
    end
endmodule // sta_bit_timer
